// [rtl/infrared_cfg.svh]
`ifndef INFRARED_CFG_SVH
`define INFRARED_CFG_SVH

`define IR_CNT_W 4
`define IR_CNT_ZERO 4'h0
`define IR_CNT_LAST 4'hF
// transmit pulse: low 0..6, high 7..9, low 10..15
`define IR_TX_HIGH_FIRST 4'h7
`define IR_TX_HIGH_LAST 4'h9
`define IR_RX_UPDATE 4'h8
`define IR_RX_WIN_OPEN 4'hC
`define IR_RX_WIN_LAST 4'h7
`define IR_CNT_STEP 4'h1
// registered pulse is high while the counter reads 8..10
`define IR_PULSE_CNT_FIRST 4'h8
`define IR_PULSE_CNT_LAST 4'hA

`endif

// [rtl/infrared_pkg.sv]
package infrared_pkg;
	typedef enum logic [1:0] {
		RX_IDLE = 2'h0,
		RX_HUNT = 2'h1,
		RX_WINDOW = 2'h3
	} rx_state_t;

	typedef struct packed {
		logic [3:0] tx_cnt;
		logic tx_bit;
		logic tx_pulse;
		logic pin_tx;
		logic uart_rxd;
		logic rx_prev;
		rx_state_t rx_state;
		logic [3:0] rx_cnt;
		logic rx_bit;
		logic rx_seen;
	} endec_state_t;
endpackage : infrared_pkg

// [rtl/infrared_pulse_endec.sv]
// Behaviour
// - when enabled, encode uart tx into pulses and decode pin pulses for uart
// - link is half-duplex; no transmit and receive at the same time
// - infrared bit rate is system clock over sixteen times baud divisor
// - every bit lasts sixteen baud clock periods both directions
// - a one bit keeps the transmit pulse low for sixteen clocks
// - a zero bit is low seven, high three, low six clocks
// - when enabled, pins carry pulse signals, uart lines stay internal
// - receiver keeps a baud clock counter wrapping zero to fifteen
// - decoded uart input lags incoming stream by eight baud clocks
// - a falling edge on incoming signal while idle or in the window resets the counter to zero
// - at count eight the uart input takes the decoded bit
// - detection window opens at twelve, stays open until count eight again
// - no pulse in window means one; return to idle, await edge
// - resynchronising the counter does not disturb the uart
// - compliant rates are 9600 baud to 115.2 kilobaud
`timescale 1ns/1ps
`include "infrared_cfg.svh"

module infrared_pulse_endec (
	input wire logic clock,
	input wire logic srst,
	input wire logic infrared_codec_enable,
	input wire logic baud_tick,
	input wire logic uart_txd,
	input wire logic rxd_pin,
	output logic txd_pin,
	output logic infrared_tx_pulse,
	output logic uart_rxd
);
	infrared_pkg::endec_state_t st_r;
	infrared_pkg::endec_state_t st_nxt;
	logic fall;

	assign txd_pin = st_r.pin_tx;
	assign infrared_tx_pulse = st_r.tx_pulse;
	assign uart_rxd = st_r.uart_rxd;
	assign fall = st_r.rx_prev & ~rxd_pin;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [`IR_CNT_W-1:0] cnt_next;
		logic tx_active;
		cnt_next = st_r.rx_cnt + `IR_CNT_STEP;
		st_nxt = st_r;
		st_nxt.rx_prev = rxd_pin;
		// a zero pulse is only sent while the receiver sits idle
		tx_active = (st_r.rx_state == infrared_pkg::RX_IDLE);
		if (!infrared_codec_enable) begin
			st_nxt.tx_cnt = `IR_CNT_ZERO;
			st_nxt.tx_pulse = 1'b0;
			st_nxt.rx_state = infrared_pkg::RX_IDLE;
			st_nxt.rx_cnt = `IR_CNT_ZERO;
			// codec off hands the raw uart lines to the pins
			st_nxt.pin_tx = uart_txd;
			st_nxt.uart_rxd = rxd_pin;
		end else begin
			// any tick spacing is taken; compliance rests on the uart's rate
			if (baud_tick) begin
				// one bit spans sixteen ticks of the baud divisor
				st_nxt.tx_cnt = st_r.tx_cnt + `IR_CNT_STEP;
				// latch the uart bit at each bit boundary
				if (st_r.tx_cnt == `IR_CNT_LAST) begin
					st_nxt.tx_bit = uart_txd;
				end
				// high only between clocks seven and nine of a zero
				st_nxt.tx_pulse = !st_r.tx_bit && tx_active &&
					(st_r.tx_cnt >= `IR_TX_HIGH_FIRST) &&
					(st_r.tx_cnt <= `IR_TX_HIGH_LAST);
			end
			// a reception in progress cuts a pulse off at once, not at the next tick
			if (!tx_active) begin
				st_nxt.tx_pulse = 1'b0;
			end
			// pin carries the modulated pulse stream
			st_nxt.pin_tx = st_nxt.tx_pulse;
			case (st_r.rx_state)
			infrared_pkg::RX_IDLE: begin
				// idle line seen by the uart is one
				st_nxt.uart_rxd = 1'b1;
				if (fall) begin
					st_nxt.rx_cnt = `IR_CNT_ZERO;
					st_nxt.rx_bit = 1'b0;
					st_nxt.rx_seen = 1'b0;
					st_nxt.rx_state = infrared_pkg::RX_HUNT;
				end
			end
			infrared_pkg::RX_HUNT, infrared_pkg::RX_WINDOW: begin
				if (fall && st_r.rx_state == infrared_pkg::RX_WINDOW) begin
					// resync only the local counter, uart untouched
					st_nxt.rx_cnt = `IR_CNT_ZERO;
					st_nxt.rx_seen = 1'b1;
					st_nxt.rx_state = infrared_pkg::RX_HUNT;
				end else if (baud_tick) begin
					// counter wraps through zero to fifteen
					st_nxt.rx_cnt = cnt_next;
					// decoded bit reaches the uart at count eight
					if (cnt_next == `IR_RX_UPDATE) begin
						st_nxt.uart_rxd = st_r.rx_bit;
						if (st_r.rx_state == infrared_pkg::RX_WINDOW) begin
							// window closed empty, a one was sent
							if (!st_r.rx_seen) begin
								st_nxt.uart_rxd = 1'b1;
								st_nxt.rx_state = infrared_pkg::RX_IDLE;
							end
						end
						st_nxt.rx_seen = 1'b0;
					end
					if (cnt_next == `IR_RX_WIN_OPEN) begin
						st_nxt.rx_state = infrared_pkg::RX_WINDOW;
					end
				end
				// pulse inside window is a zero bit
				if (fall && st_r.rx_state == infrared_pkg::RX_WINDOW) begin
					st_nxt.rx_bit = 1'b0;
				end
			end
			default: begin
				st_nxt.rx_state = infrared_pkg::RX_IDLE;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			// rx_prev starts at the idle pin level, so no false edge follows reset
			st_r <= '{tx_cnt: `IR_CNT_ZERO, tx_bit: 1'b1, tx_pulse: 1'b0, pin_tx: 1'b1,
				uart_rxd: 1'b1, rx_prev: 1'b0, rx_state: infrared_pkg::RX_IDLE,
				rx_cnt: `IR_CNT_ZERO, rx_bit: 1'b1, rx_seen: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// a one bit never raises the pulse
	one_bit_low_a: assert property (@(posedge clock) disable iff (srst)
		st_r.tx_bit |=> !st_r.tx_pulse) else $error("pulse during one bit");
	// pulse only while the counter reads eight to ten
	pulse_slot_a: assert property (@(posedge clock) disable iff (srst)
		st_r.tx_pulse |->
		st_r.tx_cnt >= `IR_PULSE_CNT_FIRST && st_r.tx_cnt <= `IR_PULSE_CNT_LAST)
		else $error("pulse outside slot");
	// falling edge in idle zeroes the counter
	edge_resync_a: assert property (@(posedge clock) disable iff (srst)
		infrared_codec_enable && fall && st_r.rx_state == infrared_pkg::RX_IDLE
		|=> st_r.rx_cnt == `IR_CNT_ZERO && st_r.rx_state == infrared_pkg::RX_HUNT)
		else $error("no resync");
	// window state only from twelve up to seven
	window_span_a: assert property (@(posedge clock) disable iff (srst)
		st_r.rx_state == infrared_pkg::RX_WINDOW |->
		(st_r.rx_cnt >= `IR_RX_WIN_OPEN || st_r.rx_cnt <= `IR_RX_WIN_LAST ||
		st_r.rx_cnt == `IR_CNT_ZERO))
		else $error("window out of span");
	// idle receiver holds uart input high
	idle_high_a: assert property (@(posedge clock) disable iff (srst)
		infrared_codec_enable && st_r.rx_state == infrared_pkg::RX_IDLE
		&& $past(st_r.rx_state) == infrared_pkg::RX_IDLE
		&& $past(infrared_codec_enable) |-> st_r.uart_rxd)
		else $error("idle not high");
	// pin follows the pulse when enabled
	pin_mux_a: assert property (@(posedge clock) disable iff (srst)
		$past(infrared_codec_enable) && infrared_codec_enable |->
		txd_pin == infrared_tx_pulse) else $error("pin mux wrong");
	half_duplex_a: assert property (@(posedge clock) disable iff (srst)
		st_r.tx_pulse |-> $past(st_r.rx_state) == infrared_pkg::RX_IDLE)
		else $error("tx during rx");
	// uart input only changes at count eight or on idle/disable
	update_point_a: assert property (@(posedge clock) disable iff (srst)
		infrared_codec_enable && $past(infrared_codec_enable) && $changed(st_r.uart_rxd)
		&& st_r.rx_state != infrared_pkg::RX_IDLE |-> st_r.rx_cnt == `IR_RX_UPDATE)
		else $error("update off count");

	// ---------------------------------------------------------------
	// step checks
	// ---------------------------------------------------------------
	// zero bit reaching its high slot while the link is free
	sequence zero_slot_s;
		infrared_codec_enable && baud_tick && !st_r.tx_bit &&
		st_r.rx_state == infrared_pkg::RX_IDLE && st_r.tx_cnt == `IR_TX_HIGH_FIRST;
	endsequence
	// tick that ends the three-clock high slot
	sequence slot_end_s;
		infrared_codec_enable && baud_tick && st_r.tx_cnt == `IR_PULSE_CNT_LAST;
	endsequence
	// empty window reaching its last count
	sequence window_empty_s;
		infrared_codec_enable && baud_tick && !fall &&
		st_r.rx_state == infrared_pkg::RX_WINDOW && st_r.rx_cnt == `IR_RX_WIN_LAST;
	endsequence
	// hunt phase reaching the update point
	sequence hunt_update_s;
		infrared_codec_enable && baud_tick &&
		st_r.rx_state == infrared_pkg::RX_HUNT && st_r.rx_cnt == `IR_RX_WIN_LAST;
	endsequence

	pulse_start_a: assert property (@(posedge clock) disable iff (srst)
		zero_slot_s |=> st_r.tx_pulse) else $error("pulse did not start");
	pulse_end_a: assert property (@(posedge clock) disable iff (srst)
		slot_end_s |=> !st_r.tx_pulse) else $error("pulse did not end");
	window_close_a: assert property (@(posedge clock) disable iff (srst)
		window_empty_s |=> st_r.uart_rxd && st_r.rx_state == infrared_pkg::RX_IDLE)
		else $error("empty window not closed");
	hunt_bit_a: assert property (@(posedge clock) disable iff (srst)
		hunt_update_s |=> st_r.uart_rxd == $past(st_r.rx_bit))
		else $error("decoded bit not passed");
	count_wrap_a: assert property (@(posedge clock) disable iff (srst)
		infrared_codec_enable && baud_tick && !fall &&
		st_r.rx_state == infrared_pkg::RX_WINDOW && st_r.rx_cnt == `IR_CNT_LAST
		|=> st_r.rx_cnt == `IR_CNT_ZERO) else $error("counter did not wrap");
	window_resync_a: assert property (@(posedge clock) disable iff (srst)
		infrared_codec_enable && fall && st_r.rx_state == infrared_pkg::RX_WINDOW
		|=> st_r.rx_cnt == `IR_CNT_ZERO && st_r.rx_state == infrared_pkg::RX_HUNT)
		else $error("window edge not resynced");
	raw_pass_a: assert property (@(posedge clock) disable iff (srst)
		!infrared_codec_enable |=>
		txd_pin == $past(uart_txd) && uart_rxd == $past(rxd_pin))
		else $error("raw lines not passed");
endmodule : infrared_pulse_endec

// [tb/ir_peer.sv]
`timescale 1ns/1ps
// ----------------
// far-side transceiver
// ----------------
module ir_peer (
	input wire logic clock,
	input wire logic baud_tick,
	output logic rxd_pin
);
	// idles low: no light, no pulse
	initial rxd_pin = 1'b0;

	task automatic send_bit(input logic b);
		int w;
		for (int i = 0; i < 16; i++) begin
			w = 0;
			do begin
				@(posedge clock);
				w++;
			end while (baud_tick !== 1'b1 && w < 8);
			if (baud_tick !== 1'b1) tb.n_fail++;
			rxd_pin <= !b && i >= 7 && i <= 9;
		end
	endtask : send_bit
endmodule : ir_peer

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic en = 1'b0;
	logic tick = 1'b0;
	logic utx = 1'b1;
	logic rxd, txd, irp, urx;
	int n_fail = 0;
	int num_checks = 0;
	int bc = 0;
	int hi;
	always #10 clock = ~clock;
	// ----------------
	// baud tick
	// ----------------
	// a tick every four cycles keeps each bit at 64 cycles, so runs stay short
	// tick spacing stands in for the uart divisor; the codec takes any rate
	always @(posedge clock) begin
		bc <= (bc + 1) % 4;
		tick <= (bc == 3);
	end
	infrared_pulse_endec u_dut (.clock(clock), .srst(srst), .infrared_codec_enable(en),
		.baud_tick(tick), .uart_txd(utx), .rxd_pin(rxd), .txd_pin(txd),
		.infrared_tx_pulse(irp), .uart_rxd(urx));
	ir_peer u_peer (.clock(clock), .baud_tick(tick), .rxd_pin(rxd));
	// ----------------
	// helpers
	// ----------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// counts ticks with the pulse high, sampled mid-cycle after each tick
	task automatic tk(input int n);
		int w;
		hi = 0;
		repeat (n) begin
			w = 0;
			do begin
				@(posedge clock);
				w++;
			end while (tick !== 1'b1 && w < 8);
			if (tick !== 1'b1) n_fail++;
			@(negedge clock);
			hi += int'(irp === 1'b1);
			if (en) chk(txd, irp);
		end
	endtask : tk
	task automatic send(input logic b);
		u_peer.send_bit(b);
		@(negedge clock);
	endtask : send
	task report_and_stop;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// ----------------
	// scenarios
	// ----------------
	task automatic test_tx;
		@(posedge clock);
		// codec enabled and the uart line driven low on the same edge
		en <= 1'b1;
		utx <= 1'b0;
		// first window absorbs the first bit, sent from the reset tx_bit before uart_txd is latched
		tk(32);
		tk(32);
		chk(hi, 6);
		@(posedge clock);
		utx <= 1'b1;
		tk(32);
		tk(32);
		chk(hi, 0);
		$display("test tx done");
	endtask : test_tx
	task automatic test_rx;
		chk(urx, 1);
		@(posedge clock);
		utx <= 1'b0;
		send(1'b0);
		chk(urx, 1);
		send(1'b0);
		chk(urx, 0);
		tk(12);
		chk(urx, 0);
		chk(hi, 0);
		tk(10);
		chk(urx, 1);
		$display("test rx done");
	endtask : test_rx
	task automatic test_off;
		@(posedge clock);
		en <= 1'b0;
		tk(1);
		chk({txd, urx}, 8'h00);
		@(posedge clock);
		utx <= 1'b1;
		tk(1);
		chk(txd, 1);
		$display("test off done");
	endtask : test_off
	initial begin
		repeat (5) @(posedge clock);
		@(negedge clock);
		chk({txd, irp, urx}, 8'h05);
		@(posedge clock);
		srst <= 1'b0;
		test_tx();
		test_rx();
		test_off();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		report_and_stop();
	end
endmodule : tb
